// ===== hw/fps_ctl_if.sv
// Carrier between the fan control core, spin-up timer and waveform generator
`timescale 1ns/10ps
interface fps_ctl_if;
  logic ce;
  logic kick_start;
  logic kick_stop;
  logic [3:0] kick_len;
  logic kick_busy;
  logic [3:0] drive_code;
  logic fast_map;
  logic polarity_flip;
  logic fan_out;
  modport ctl (output ce, kick_start, kick_stop, kick_len, drive_code,
               fast_map, polarity_flip, input kick_busy, fan_out);
  modport kick (input ce, kick_start, kick_stop, kick_len, output kick_busy);
  modport pwm (input ce, drive_code, fast_map, polarity_flip, output fan_out);
endinterface

// ===== hw/fps_kick_timer.sv
// Spin-up duration timer counting millisecond ticks
`timescale 1ns/10ps
module fps_kick_timer #(
  parameter int unsigned TICK_CYCLES = fps_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  fps_ctl_if.kick ctl
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  fps_pkg::fps_kick_e state_ff, nxt_state;
  logic [14:0] ms_left_ff, nxt_ms_left;
  logic [TW-1:0] tick_ff, nxt_tick;
  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------
  // Length code to milliseconds by table; code 0 gives zero, no run
  wire [14:0] load_ms = fps_pkg::KICK_MS[ctl.kick_len];
  wire tick_done = tick_ff == TW'(TICK_CYCLES - 1);
  assign ctl.kick_busy = state_ff == fps_pkg::KICK_RUN;
  // Next state; a start while running is ignored, no reload
  always_comb
  begin
    nxt_state = state_ff;
    nxt_ms_left = ms_left_ff;
    nxt_tick = tick_ff;
    case (state_ff)
      fps_pkg::KICK_IDLE:
      begin
        if (ctl.kick_start && load_ms != 15'h0000)
        begin
          nxt_state = fps_pkg::KICK_RUN;
          nxt_ms_left = load_ms;
          nxt_tick = '0;
        end
      end
      fps_pkg::KICK_RUN:
      begin
        if (ctl.kick_stop)
          nxt_state = fps_pkg::KICK_IDLE;
        else if (tick_done)
        begin
          nxt_tick = '0;
          nxt_ms_left = ms_left_ff - 15'h0001;
          if (ms_left_ff == 15'h0001)
            nxt_state = fps_pkg::KICK_IDLE;
        end
        else
          nxt_tick = tick_ff + TW'(1);
      end
      default: nxt_state = fps_pkg::KICK_IDLE;
    endcase
  end
  // State registers, frozen while clock enable is low
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= fps_pkg::KICK_IDLE;
      ms_left_ff <= 15'h0000;
      tick_ff <= '0;
    end
    else if (ctl.ce)
    begin
      state_ff <= nxt_state;
      ms_left_ff <= nxt_ms_left;
      tick_ff <= nxt_tick;
    end
  end
endmodule

// ===== hw/fps_pkg.sv
// Shared constants and types for the fan drive control block
package fps_pkg;
  // --------------------------------------------------------------
  // Register byte addresses and reset values
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_BIND = 8'hC8;
  localparam logic [7:0] ADDR_FORCE = 8'hC9;
  localparam logic [7:0] ADDR_KICK = 8'hCA;
  localparam logic [7:0] RST_BIND = 8'h00;
  localparam logic [7:0] RST_FORCE = 8'h00;
  localparam logic [7:0] RST_KICK = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;
  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int BIND_ZONE_LO = 0;
  localparam int BIND_THROTTLE = 4;
  localparam int BIND_REGULATOR = 6;
  localparam int FORCE_EN = 0;
  localparam int FORCE_FLIP = 1;
  localparam int FORCE_LATCH_EN = 2;
  localparam int FORCE_LATCH = 3;
  localparam int FORCE_LEVEL_LO = 4;
  localparam int KICK_DUTY_LO = 0;
  localparam int KICK_LEN_MSB = 4;
  localparam int KICK_LEN_LO = 5;
  // --------------------------------------------------------------
  // Duty codes and waveform map
  // --------------------------------------------------------------
  localparam logic [3:0] CODE_ZERO = 4'h0;
  localparam logic [3:0] CODE_FULL = 4'hF;
  localparam logic [3:0] STEP_LAST = 4'hD;
  localparam logic [6:0] PWM_PERIOD = 7'h70;
  localparam logic [6:0] HF_STEP_CNT = 7'h07;
  localparam logic [6:0] HF_BASE = 7'h03;
  localparam logic [6:0] LF_STEP_CNT = 7'h04;
  localparam logic [6:0] LF_BASE = 7'h06;
  localparam logic [3:0] LF_KNEE = 4'hA;
  localparam logic [6:0] LF_STEP11 = 7'h50;
  localparam logic [6:0] LF_STEP12 = 7'h60;
  // --------------------------------------------------------------
  // Timing: one millisecond tick, spin-up lengths in milliseconds
  // --------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 25000000;
  localparam int unsigned TICK_TIME_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
  localparam logic [14:0] KICK_MS [16] = '{
    15'h0000, 15'h0064, 15'h00FA, 15'h0190, 15'h02BC, 15'h03E8, 15'h07D0, 15'h0FA0,
    15'h1770, 15'h1F40, 15'h2710, 15'h2EE0, 15'h36B0, 15'h3E80, 15'h4650, 15'h4E20};
  typedef enum logic [0:0] {
    KICK_IDLE = 1'b0,
    KICK_RUN = 1'b1
  } fps_kick_e;
endpackage

// ===== hw/fps_pwm_gen.sv
// Duty code to waveform generator with the two step maps
`timescale 1ns/10ps
module fps_pwm_gen (
  input wire logic core_clk,
  input wire logic nrst,
  fps_ctl_if.pwm ctl
);
  logic [6:0] cnt_ff;
  logic out_ff;
  // --------------------------------------------------------------
  // Code to step to on-count
  // --------------------------------------------------------------
  // Sixteen codes, fourteen distinct steps; codes above last clamp
  wire [3:0] step = (ctl.drive_code > fps_pkg::STEP_LAST) ? fps_pkg::STEP_LAST :
                    ctl.drive_code;
  wire [6:0] step_w = {3'h0, step};
  // Fast map: 18.75% plus 6.25% per step
  wire [6:0] hf_on = (step_w + fps_pkg::HF_BASE) * fps_pkg::HF_STEP_CNT;
  wire [6:0] lf_on = (step <= fps_pkg::LF_KNEE) ?
                     (step_w + fps_pkg::LF_BASE) * fps_pkg::LF_STEP_CNT :
                     (step == fps_pkg::STEP_LAST) ? fps_pkg::PWM_PERIOD :
                     (step == fps_pkg::LF_KNEE + 4'h1) ? fps_pkg::LF_STEP11 :
                     fps_pkg::LF_STEP12;
  wire [6:0] on_cnt = (step == fps_pkg::CODE_ZERO) ? 7'h00 :
                      ctl.fast_map ? hf_on : lf_on;
  // Full on-count keeps the raw level high all period
  wire raw_level = cnt_ff < on_cnt;
  wire cnt_wrap = cnt_ff == fps_pkg::PWM_PERIOD - 7'h01;
  assign ctl.fan_out = out_ff;
  // Period counter and registered, polarity-adjusted output
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_ff <= 7'h00;
      out_ff <= 1'b0;
    end
    else if (ctl.ce)
    begin
      cnt_ff <= cnt_wrap ? 7'h00 : cnt_ff + 7'h01;
      out_ff <= raw_level ^ ctl.polarity_flip;
    end
  end
endmodule

// ===== hw/fps_top.sv
// Fan drive control: source binding, largest-request pick, manual request, latch, spin-up
`timescale 1ns/10ps
module fps_top #(
  parameter int unsigned TICK_CYCLES = fps_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic config_freeze,
  input wire logic fast_freq_sel,
  input wire logic fast_rate_step_map,
  input wire logic [3:0][3:0] zone_request_code,
  input wire logic [3:0] throttle_ramp_code,
  input wire logic [3:0] regulator_ramp_code,
  input wire logic processor_throttle_signal,
  output logic fan_drive_output,
  output logic kick_active
);
  // --------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------
  logic [7:0] bind_ff;
  logic [2:0] force_ctl_ff;
  logic [3:0] level_wr_ff;
  logic full_latch_ff;
  logic [7:0] kick_ff;
  logic [3:0] prev_req_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic nxt_full_latch;
  logic [7:0] nxt_rdata;
  logic [3:0] req_code;
  fps_ctl_if ctl ();

  // --------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------
  // Address hits
  wire hit_bind = reg_addr == fps_pkg::ADDR_BIND;
  wire hit_force = reg_addr == fps_pkg::ADDR_FORCE;
  wire hit_kick = reg_addr == fps_pkg::ADDR_KICK;
  // Freeze blocks configuration writes but never the latch bit
  wire wr_bind = reg_wr && hit_bind && !config_freeze;
  wire wr_force_cfg = reg_wr && hit_force && !config_freeze;
  wire wr_force_any = reg_wr && hit_force;
  wire wr_kick = reg_wr && hit_kick && !config_freeze;

  // Named fields of the stored registers
  wire [3:0] zone_table_bind = bind_ff[fps_pkg::BIND_ZONE_LO +: 4];
  wire throttle_source_bind = bind_ff[fps_pkg::BIND_THROTTLE];
  wire regulator_source_bind = bind_ff[fps_pkg::BIND_REGULATOR];
  wire manual_duty_force = force_ctl_ff[fps_pkg::FORCE_EN];
  wire output_polarity_flip = force_ctl_ff[fps_pkg::FORCE_FLIP];
  wire throttle_latch_enable = force_ctl_ff[fps_pkg::FORCE_LATCH_EN];
  wire [3:0] manual_duty_level = level_wr_ff;
  wire [3:0] kickstart_duty = kick_ff[fps_pkg::KICK_DUTY_LO +: 4];
  // Length msb sits below the three low bits
  wire [3:0] kickstart_length = {kick_ff[fps_pkg::KICK_LEN_MSB],
                                 kick_ff[fps_pkg::KICK_LEN_LO +: 3]};

  // --------------------------------------------------------------
  // Source requests
  // --------------------------------------------------------------
  // Eight request slots: four zones, throttle, regulator, manual, latch
  logic [7:0][3:0] src_code;
  logic [7:0] src_on;
  logic [7:0][3:0] gated_code;
  // Zone slots carry table codes
  assign src_code[3:0] = zone_request_code;
  assign src_on[3:0] = zone_table_bind;
  // Throttle slot carries its ramp code
  assign src_code[4] = throttle_ramp_code;
  assign src_on[4] = throttle_source_bind;
  // Regulator slot carries its ramp code
  assign src_code[5] = regulator_ramp_code;
  assign src_on[5] = regulator_source_bind;
  // Manual level joins as one more request, not a hard force
  assign src_code[6] = manual_duty_level;
  assign src_on[6] = manual_duty_force;
  // Latch requests full duty, which no other code can exceed
  assign src_code[7] = fps_pkg::CODE_FULL;
  assign src_on[7] = full_latch_ff;

  // Unbound slots request zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_gate
      assign gated_code[gi] = src_on[gi] ? src_code[gi] : fps_pkg::CODE_ZERO;
    end
  endgenerate

  // Largest code wins; codes rise with duty so codes compare directly
  always_comb
  begin
    req_code = fps_pkg::CODE_ZERO;
    for (int i = 0; i < 8; i++)
    begin
      if (gated_code[i] > req_code)
        req_code = gated_code[i];
    end
  end

  // --------------------------------------------------------------
  // Spin-up control
  // --------------------------------------------------------------
  // Rising from zero starts a kick unless its duty is zero
  wire rise_from_zero = prev_req_ff == fps_pkg::CODE_ZERO && req_code != fps_pkg::CODE_ZERO;
  wire kick_allowed = kickstart_duty != fps_pkg::CODE_ZERO;
  assign ctl.ce = ce;
  assign ctl.kick_start = rise_from_zero && kick_allowed;
  // Dropping back to zero ends a kick so a stopped fan is not kept spinning
  assign ctl.kick_stop = req_code == fps_pkg::CODE_ZERO;
  assign ctl.kick_len = kickstart_length;
  // Kick duty replaces the request while running, except under latch
  wire kick_drives = ctl.kick_busy && !full_latch_ff;
  assign ctl.drive_code = kick_drives ? kickstart_duty : req_code;
  // Fast map applies only at the fast output rate
  assign ctl.fast_map = fast_rate_step_map && fast_freq_sel;
  assign ctl.polarity_flip = output_polarity_flip;

  // --------------------------------------------------------------
  // Full-speed latch
  // --------------------------------------------------------------
  // Set needs the enable, binding and event
  wire latch_set = throttle_latch_enable && throttle_source_bind && processor_throttle_signal;
  // Zero write clears; a set in the same cycle wins
  wire latch_clr = wr_force_any && !reg_wdata[fps_pkg::FORCE_LATCH];
  always_comb
  begin
    nxt_full_latch = full_latch_ff;
    if (latch_set)
      nxt_full_latch = 1'b1;
    else if (latch_clr)
      nxt_full_latch = 1'b0;
  end

  // --------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------
  // Level reads the driving code, zero during a kick
  wire [3:0] level_read = ctl.kick_busy ? fps_pkg::CODE_ZERO : ctl.drive_code;
  wire [7:0] force_read = {level_read, full_latch_ff, force_ctl_ff};
  // Unmapped addresses read as zero
  always_comb
  begin
    nxt_rdata = fps_pkg::READ_NONE;
    if (hit_bind)
      nxt_rdata = bind_ff;
    else if (hit_force)
      nxt_rdata = force_read;
    else if (hit_kick)
      nxt_rdata = kick_ff;
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  // Configuration registers; reserved binding bits are kept as written
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bind_ff <= fps_pkg::RST_BIND;
      force_ctl_ff <= fps_pkg::RST_FORCE[2:0];
      level_wr_ff <= fps_pkg::RST_FORCE[7:4];
      kick_ff <= fps_pkg::RST_KICK;
    end
    else if (ce)
    begin
      if (wr_bind)
        bind_ff <= reg_wdata;
      if (wr_force_cfg)
        force_ctl_ff <= reg_wdata[2:0];
      if (wr_force_cfg)
        level_wr_ff <= reg_wdata[fps_pkg::FORCE_LEVEL_LO +: 4];
      if (wr_kick)
        kick_ff <= reg_wdata;
    end
  end

  // Latch and the previous request for zero detection
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      full_latch_ff <= fps_pkg::RST_FORCE[fps_pkg::FORCE_LATCH];
      prev_req_ff <= fps_pkg::CODE_ZERO;
    end
    else if (ce)
    begin
      full_latch_ff <= nxt_full_latch;
      prev_req_ff <= req_code;
    end
  end

  // Read data lands one cycle after the read strobe
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_ff <= fps_pkg::READ_NONE;
      rvalid_ff <= 1'b0;
    end
    else if (ce)
    begin
      rvalid_ff <= reg_rd;
      if (reg_rd)
        rdata_ff <= nxt_rdata;
    end
  end

  // --------------------------------------------------------------
  // Sub-blocks and outputs
  // --------------------------------------------------------------
  // Spin-up timer
  fps_kick_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_kick (
    .core_clk(core_clk),
    .nrst(nrst),
    .ctl(ctl)
  );
  // Waveform generator, maps duty for all sources alike
  fps_pwm_gen u_pwm (
    .core_clk(core_clk),
    .nrst(nrst),
    .ctl(ctl)
  );
  assign fan_drive_output = ctl.fan_out;
  assign kick_active = ctl.kick_busy;
  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  latch_never_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !full_latch_ff && !throttle_latch_enable |=> !full_latch_ff)
    else $error("full-speed latch set while disabled");

  latch_set_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    ce && throttle_latch_enable && throttle_source_bind && processor_throttle_signal
    |=> full_latch_ff)
    else $error("bound throttle event did not set latch");

  latch_full_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    full_latch_ff |-> ctl.drive_code == fps_pkg::CODE_FULL)
    else $error("latched output not at full duty");

  latch_clear_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    ce && reg_wr && hit_force && !reg_wdata[3] && !latch_set |=> !full_latch_ff)
    else $error("zero write did not clear latch");

  freeze_hold_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    ce && config_freeze && reg_wr && hit_bind |=> $stable(bind_ff))
    else $error("frozen binding register changed");

  largest_pick_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !ctl.kick_busy && zone_table_bind[0] && throttle_source_bind
    |-> ctl.drive_code >= zone_request_code[0] && ctl.drive_code >= throttle_ramp_code)
    else $error("drive below a bound request");

  manual_req_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !ctl.kick_busy && manual_duty_force |-> ctl.drive_code >= manual_duty_level)
    else $error("manual level not honoured");

  kick_read_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    ce && reg_rd && hit_force && ctl.kick_busy |=> reg_rvalid && reg_rdata[7:4] == 4'h0)
    else $error("level read nonzero during spin-up");

  kick_start_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    ce && ctl.kick_start && kickstart_length != 4'h0 |=> ##[0:1] kick_active)
    else $error("spin-up did not start");

  kick_off_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !ctl.kick_busy && kickstart_duty == 4'h0 |=> !ctl.kick_busy)
    else $error("spin-up ran with zero duty");

  polarity_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $past(ce) && $past(ctl.drive_code) == fps_pkg::CODE_FULL
    |-> fan_drive_output == !$past(output_polarity_flip))
    else $error("full duty level has wrong polarity");

  unbound_zero_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !ctl.kick_busy && !full_latch_ff && !manual_duty_force && zone_table_bind == 4'h0
    && !throttle_source_bind && !regulator_source_bind
    |-> ctl.drive_code == fps_pkg::CODE_ZERO)
    else $error("unbound output requests nonzero duty");

  throttle_bind_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !ctl.kick_busy && throttle_source_bind |-> ctl.drive_code >= throttle_ramp_code)
    else $error("drive below bound throttle request");

  regulator_bind_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !ctl.kick_busy && regulator_source_bind |-> ctl.drive_code >= regulator_ramp_code)
    else $error("drive below bound regulator request");

  level_read_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    ce && reg_rd && hit_force && !ctl.kick_busy
    |=> reg_rdata[7:4] == $past(ctl.drive_code))
    else $error("level read differs from driving code");

  kick_duty_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    ctl.kick_busy && !full_latch_ff |-> ctl.drive_code == kickstart_duty)
    else $error("spin-up not driving its duty");
endmodule

// ===== verification/fps_fan_model.sv
// Fan drive transistor and processor throttle source model
`timescale 1ns/10ps
module fps_fan_model (
  input wire logic core_clk,
  input wire logic fan_drive_output,
  input wire logic hot_req,
  input wire logic cnt_clr,
  output logic processor_throttle_signal,
  output logic [7:0] on_cnt
);
  // Throttle line follows the bench request; on-time of the fan is summed per window
  always_ff @(posedge core_clk)
  begin
    processor_throttle_signal <= hot_req;
    on_cnt <= cnt_clr ? 8'h00 : on_cnt + {7'h00, fan_drive_output};
  end
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the fan drive control block
`timescale 1ns/10ps
module testbench;
  logic core_clk, nrst, reg_wr, reg_rd, reg_rvalid, freeze, fsel, fmap, hot, clr;
  logic fan_out, kick, thr, en;
  logic [7:0] addr, wdata, rdata, on_cnt;
  int err_total, cmp_count, kcnt;
  // ------------------------------------------------------------
  // Design, fan model and clock
  // ------------------------------------------------------------
  // Short tick keeps the spin-up run brief: 100 ms code becomes 200 cycles
  fps_top #(.TICK_CYCLES(2)) uut (.core_clk(core_clk), .nrst(nrst), .ce(en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .reg_rvalid(reg_rvalid), .config_freeze(freeze),
    .fast_freq_sel(fsel), .fast_rate_step_map(fmap),
    .zone_request_code({4'h4, 4'h3, 4'h2, 4'h1}), .throttle_ramp_code(4'h5),
    .regulator_ramp_code(4'h6), .processor_throttle_signal(thr),
    .fan_drive_output(fan_out), .kick_active(kick));
  fps_fan_model fan (.core_clk(core_clk), .fan_drive_output(fan_out), .hot_req(hot),
    .cnt_clr(clr), .processor_throttle_signal(thr), .on_cnt(on_cnt));
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Spin-up cycles counted in the background
  always @(negedge core_clk)
    kcnt += int'(kick === 1'b1);
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write strobe lasts one cycle; two idle cycles let the drive code settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    addr = a;
    wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk("read valid", 9'h001, {8'h00, reg_rvalid});
    chk($sformatf("reg %h", a), {1'b0, exp}, {1'b0, rdata});
  endtask
  // Two periods to settle, then one full 112-cycle window of on-time
  task automatic duty(input logic [8:0] exp);
    repeat (224) @(negedge core_clk);
    clr = 1'b1;
    @(negedge core_clk);
    clr = 1'b0;
    repeat (112) @(negedge core_clk);
    chk("on cycles", exp, {1'b0, on_cnt});
  endtask
  task automatic pulse;
    hot = 1'b1;
    repeat (3) @(negedge core_clk);
    hot = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Clock enable low must ignore a write strobe
  task automatic t_reset;
    en = 1'b0;
    wr(8'hC8, 8'h01);
    en = 1'b1;
    rdc(8'hC8, 8'h00);
    rdc(8'hC9, 8'h00);
    rdc(8'hCA, 8'h00);
    rdc(8'h55, 8'h00);
  endtask
  // Zone codes 1..4, throttle 5, regulator 6; reserved bits bind nothing
  task automatic t_bind;
    logic [7:0] bv [6] = '{8'h01, 8'h0F, 8'h1F, 8'h5F, 8'h40, 8'hA0};
    logic [3:0] cv [6] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h6, 4'h0};
    for (int i = 0; i < 6; i++)
    begin
      wr(8'hC8, bv[i]);
      rdc(8'hC8, bv[i]);
      rdc(8'hC9, {cv[i], 4'h0});
    end
    wr(8'hC8, 8'h5F);
    duty(9'h030);
    wr(8'hC8, 8'hA0);
  endtask
  task automatic t_force;
    wr(8'hC9, 8'hA1);
    rdc(8'hC9, 8'hA1);
    duty(9'h040);
    wr(8'hC9, 8'hA3);
    duty(9'h030);
    wr(8'hC9, 8'hE1);
    duty(9'h070);
    fsel = 1'b1;
    fmap = 1'b1;
    wr(8'hC9, 8'h51);
    duty(9'h038);
    fmap = 1'b0;
    duty(9'h02C);
    fsel = 1'b0;
    wr(8'hC9, 8'h00);
  endtask
  task automatic t_latch;
    wr(8'hC8, 8'h10);
    pulse();
    rdc(8'hC9, 8'h50);
    wr(8'hC9, 8'h04);
    pulse();
    rdc(8'hC9, 8'hFC);
    duty(9'h070);
    freeze = 1'b1;
    wr(8'hC8, 8'h00);
    rdc(8'hC8, 8'h10);
    wr(8'hC9, 8'h00);
    rdc(8'hC9, 8'h54);
    freeze = 1'b0;
    wr(8'hC9, 8'h00);
    wr(8'hC8, 8'h00);
  endtask
  // Length code 1 is 100 ms, spin-up duty 3
  task automatic t_kick;
    chk("no spin-up yet", 9'h000, kcnt[8:0]);
    wr(8'hCA, 8'h23);
    rdc(8'hCA, 8'h23);
    kcnt = 0;
    wr(8'hC8, 8'h01);
    chk("spin-up running", 9'h001, {8'h00, kick});
    rdc(8'hC9, 8'h00);
    repeat (400) @(negedge core_clk);
    chk("spin-up cycles", 9'h0C8, kcnt[8:0]);
    rdc(8'hC9, 8'h10);
  endtask
  task automatic final_report;
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    {nrst, reg_wr, reg_rd, freeze, fsel, fmap, hot, clr} = 8'h00;
    addr = 8'h00;
    en = 1'b1;
    wdata = 8'h00;
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    t_reset();
    t_bind();
    t_force();
    t_latch();
    t_kick();
    final_report();
  end
  // Whole sequence needs about 2900 cycles; a hang is cut at 20000
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    final_report();
  end
endmodule
